// ==== src/pbpm_bank.sv ====
// Function
// RQ1: event support and event clock read zero
// RQ2: D2 unsupported reads 0, D1 reads 1
// RQ3: auxiliary current field is constant zero
// RQ4: version field always reads binary 010
// RQ5: device specific init bit reset to 0
// RQ6: event status, scale, select, enable read zero
// RQ7: two-bit power state field, D0 to D3hot
// RQ8: unsupported state write leaves field unchanged
// RQ9: any host write to 5c-5f is request
// RQ10: host write sets request bit, drives interrupt
// RQ11: requested state from host only, local ignored
// RQ12: delayed enable retries host until accept set; code accepts a D3hot to D0 write with byte 0 enabled without it
// RQ13: accept reads 1 without delay, cleared on accept
// RQ14: after clear, no new request until accepted
// RQ15: local clears request and sets accept together
// RQ16: base bits writable only where mask is 1
// RQ17: base low bits zero, prefetchable one
// RQ18: local master sets size mask before host config
// RQ19: detected parity set on any parity error
// RQ20: system error and abort flags, write 1 clear
// RQ21: device select timing always reads 01
// RQ22: data parity set as master when enabled
//
// configuration register bank of the bridge: host configuration port and
// local address/data port; event inputs arrive from pins, only the system error and parity error pins synchronised here
`timescale 1ns/1ps
`include "pbpm_map.svh"
module pbpm_bank #(
   parameter logic [7:0]  REVISION  = 8'h01, // arbitrary value
   parameter logic [7:0]  BRIDGE_EXT = 8'h00
) (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        host_wr,
   input  wire logic        host_rd,
   input  wire logic [7:0]  host_addr,
   input  wire logic [3:0]  host_be,
   input  wire logic [31:0] host_wdata,
   input  wire logic        local_wr,
   input  wire logic        local_rd,
   input  wire logic [7:0]  local_addr,
   input  wire logic [31:0] local_wdata,
   input  wire logic        addr_parity_err,
   input  wire logic        data_parity_err,
   input  wire logic        system_error_pin,
   input  wire logic        master_abort_evt,
   input  wire logic        target_abort_evt,
   input  wire logic        signaled_abort_evt,
   input  wire logic        read_parity_err,
   input  wire logic        parity_error_pin,
   input  wire logic        master_write,
   input  wire logic        parity_response_enable,
   output logic [31:0]      rdata,
   output logic             host_retry,
   output logic             local_irq
);
   pbpm_pkg::pbpm_state_t s;
   pbpm_pkg::pbpm_state_t next_s;

   // dword-aligned register image seen by either port
   function automatic logic [31:0] read_word(input logic [7:0] a,
                                             input pbpm_pkg::pbpm_state_t c);
      logic [15:0] cap;
      logic [15:0] csr;
      logic [15:0] st;
      cap = 16'h0000; // RQ1 RQ3
      cap[`PBPM_CAP_D1_BIT] = `PBPM_CAP_D1; // RQ2
      cap[`PBPM_CAP_D2_BIT] = `PBPM_CAP_D2; // RQ2
      cap[5] = c.dsi;
      cap[2:0] = `PBPM_CAP_VERSION; // RQ4
      csr = {14'h0000, c.power_state_field}; // RQ6 RQ7
      st = 16'h0000;
      st[`PBPM_STAT_DETECTED_PARITY_FLAG] = c.status_flags[5];
      st[`PBPM_STAT_SSE] = c.status_flags[4];
      st[`PBPM_STAT_RMA] = c.status_flags[3];
      st[`PBPM_STAT_RTA] = c.status_flags[2];
      st[`PBPM_STAT_STA] = c.status_flags[1];
      st[`PBPM_STAT_DPE] = c.status_flags[0];
      st[10:9] = `PBPM_DEVSEL_TIMING; // RQ21
      st[4] = 1'b1;
      read_word = 32'h0000_0000;
      case (a & 8'hfc)
         8'h04: read_word = {st, 16'h0000};
         `PBPM_OFF_REVID: read_word = {24'h000000, REVISION};
         `PBPM_OFF_BASE1:
            read_word = {c.base_one & c.mask_one, `PBPM_BAR_LOW}; // RQ16 RQ17
         `PBPM_OFF_BASE2:
            read_word = {c.base_two & c.mask_two, `PBPM_BAR_LOW}; // RQ16 RQ17
         `PBPM_OFF_SUBSYS: read_word = {c.submaker, c.subsys};
         `PBPM_OFF_BESR1:
            read_word = {10'h000, c.master5_syndrome_lock,
                         c.master5_address_lock, 20'h00000};
         8'h58: read_word = {cap, 16'h0000};
         `PBPM_OFF_PMCSR: read_word = {8'h00, BRIDGE_EXT, csr};
         `PBPM_OFF_SCRR:
            read_word = {27'h0000000,
                         c.accept_bit | ~c.delayed_write_enable, // RQ13
                         c.state_change_request,
                         c.requested_power_state,
                         c.delayed_write_enable};
         `PBPM_OFF_MASK1: read_word = {c.mask_one, 12'h000};
         `PBPM_OFF_MASK2: read_word = {c.mask_two, 12'h000};
         default: read_word = 32'h0000_0000;
      endcase
   endfunction

   function automatic logic state_ok(input logic [1:0] v);
      state_ok = (v != `PBPM_ST_D2); // RQ8
   endfunction

   logic [5:0]  ev;
   logic        csr_hit;
   logic        accepted;
   logic [1:0]  wstate;

   always_comb begin
      next_s = s;
      ev = 6'h00;
      csr_hit = host_wr && ((host_addr & 8'hfc) == `PBPM_OFF_PMCSR); // RQ9
      wstate = host_wdata[1:0];
      // D3hot to D0 bypasses the delay; accept is 1 when delay is off
      accepted = !s.delayed_write_enable || s.accept_bit ||
                 (s.power_state_field == `PBPM_ST_D3 &&
                  wstate == `PBPM_ST_D0 && host_be[0]); // RQ12
      next_s.retry = 1'b0;
      next_s.pin_sync0 = {system_error_pin, parity_error_pin, 1'b0};
      next_s.pin_sync1 = s.pin_sync0;
      if (csr_hit) begin
         if (accepted) begin
            if (host_be[0] && state_ok(wstate))
               next_s.power_state_field = wstate; // RQ7 RQ8
            next_s.accept_bit = 1'b0; // RQ13
            next_s.held = 1'b0;
         end else begin
            next_s.retry = 1'b1; // RQ12
         end
         if (!s.held) begin
            next_s.state_change_request = 1'b1; // RQ10
            next_s.requested_power_state = wstate; // RQ11
            next_s.held = !accepted;
         end
      end
      if (host_wr && ((host_addr & 8'hfc) == `PBPM_OFF_BASE1))
         next_s.base_one = host_wdata[31:12] & s.mask_one; // RQ16
      if (host_wr && ((host_addr & 8'hfc) == `PBPM_OFF_BASE2))
         next_s.base_two = host_wdata[31:12] & s.mask_two; // RQ16
      if (host_wr && ((host_addr & 8'hfc) == `PBPM_OFF_SUBSYS)) begin
         if (host_be[1:0] != 2'b00) next_s.subsys = host_wdata[15:0];
         if (host_be[3:2] != 2'b00) next_s.submaker = host_wdata[31:16];
      end
      // local side: request bit and accept are software-owned
      if (local_wr) begin
         case (local_addr & 8'hfc)
            `PBPM_OFF_SCRR: begin
               next_s.delayed_write_enable = local_wdata[`PBPM_SCRR_DWE];
               next_s.accept_bit = local_wdata[`PBPM_SCRR_APW]; // RQ15
               if (!(csr_hit && !s.held))
                  next_s.state_change_request =
                     local_wdata[`PBPM_SCRR_SCR]; // RQ14
            end
            `PBPM_OFF_MASK1: next_s.mask_one = local_wdata[31:12]; // RQ18
            `PBPM_OFF_MASK2: next_s.mask_two = local_wdata[31:12]; // RQ18
            `PBPM_OFF_BESR1: begin
               next_s.master5_syndrome_lock = local_wdata[`PBPM_BESR1_FL];
               next_s.master5_address_lock = local_wdata[`PBPM_BESR1_AL];
            end
            default: next_s.dsi = s.dsi;
         endcase
      end
      // status flags: write 1 clears, a same-cycle event wins
      if (host_wr && ((host_addr & 8'hfc) == 8'h04) && host_be[3])
         next_s.status_flags[5:4] = s.status_flags[5:4] &
            ~{host_wdata[16 + `PBPM_STAT_DETECTED_PARITY_FLAG], host_wdata[16 + `PBPM_STAT_SSE]};
      if (host_wr && ((host_addr & 8'hfc) == 8'h04) && host_be[3])
         next_s.status_flags[3:1] = s.status_flags[3:1] &
            ~{host_wdata[16 + `PBPM_STAT_RMA], host_wdata[16 + `PBPM_STAT_RTA],
              host_wdata[16 + `PBPM_STAT_STA]};
      // data parity flag sits at status bit 8, i.e. in the top byte lane
      if (host_wr && ((host_addr & 8'hfc) == 8'h04) && host_be[3])
         next_s.status_flags[0] = s.status_flags[0] &
            ~host_wdata[16 + `PBPM_STAT_DPE];
      ev[5] = addr_parity_err | data_parity_err | read_parity_err; // RQ19
      ev[4] = s.pin_sync1[2]; // RQ20
      ev[3] = master_abort_evt; // RQ20
      ev[2] = target_abort_evt; // RQ20
      ev[1] = signaled_abort_evt; // RQ20
      ev[0] = parity_response_enable &&
              (read_parity_err || (master_write && s.pin_sync1[1])); // RQ22
      next_s.status_flags = next_s.status_flags | ev;
      next_s.irq = next_s.state_change_request; // RQ10
      next_s.rdata = 32'h0000_0000;
      if (host_rd) next_s.rdata = read_word(host_addr, s);
      else if (local_rd) next_s.rdata = read_word(local_addr, s);
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s <= '0; // RQ5
      end else begin
         s <= next_s;
      end
   end

   assign rdata = s.rdata;
   assign host_retry = s.retry;
   assign local_irq = s.irq;
endmodule

// ==== src/pbpm_map.svh ====
// register offsets, field positions and constant values for the bridge
// configuration registers; included by the design
`ifndef PBPM_MAP_SVH
`define PBPM_MAP_SVH
`define PBPM_OFF_STATUS      8'h06
`define PBPM_OFF_REVID       8'h08
`define PBPM_OFF_BASE1       8'h14
`define PBPM_OFF_BASE2       8'h18
`define PBPM_OFF_SUBSYS      8'h2c
`define PBPM_OFF_SUBMAKER    8'h2e
`define PBPM_OFF_PMCAP       8'h5a
`define PBPM_OFF_PMCSR       8'h5c
`define PBPM_OFF_PMBSE       8'h5e
`define PBPM_OFF_SCRR        8'h64
`define PBPM_OFF_BESR1       8'h50
`define PBPM_OFF_MASK1       8'h70
`define PBPM_OFF_MASK2       8'h74
`define PBPM_CAP_VERSION     3'h2
`define PBPM_CAP_D1          1'b1
`define PBPM_CAP_D2          1'b0
`define PBPM_CAP_D1_BIT      9
`define PBPM_CAP_D2_BIT      10
`define PBPM_BAR_LOW         12'h008
`define PBPM_DEVSEL_TIMING   2'h1
`define PBPM_ST_D0           2'h0
`define PBPM_ST_D1           2'h1
`define PBPM_ST_D2           2'h2
`define PBPM_ST_D3           2'h3
`define PBPM_SCRR_DWE        0
`define PBPM_SCRR_SCR        3
`define PBPM_SCRR_APW        4
`define PBPM_BESR1_FL        21
`define PBPM_BESR1_AL        20
`define PBPM_STAT_DETECTED_PARITY_FLAG       15
`define PBPM_STAT_SSE        14
`define PBPM_STAT_RMA        13
`define PBPM_STAT_RTA        12
`define PBPM_STAT_STA        11
`define PBPM_STAT_DPE        8
`endif

// ==== src/pbpm_pkg.sv ====
// types shared by the bridge configuration register bank
package pbpm_pkg;
   typedef struct packed {
      logic [1:0]  power_state_field;
      logic [1:0]  requested_power_state;
      logic        state_change_request;
      logic        accept_bit;
      logic        delayed_write_enable;
      logic        dsi;
      logic        held;
      logic [19:0] base_one;
      logic [19:0] base_two;
      logic [19:0] mask_one;
      logic [19:0] mask_two;
      logic [15:0] subsys;
      logic [15:0] submaker;
      logic [5:0]  status_flags;
      logic        master5_syndrome_lock;
      logic        master5_address_lock;
      logic [31:0] rdata;
      logic        retry;
      logic        irq;
      logic [2:0]  pin_sync0;
      logic [2:0]  pin_sync1;
   } pbpm_state_t;
endpackage

// ==== verif/pbpm_bank_props.sv ====
// assertions on the register bank ports
// assumes one clock domain, bound to every pbpm_bank
`timescale 1ns/1ps
module pbpm_bank_props (
   input wire logic        clk_sys,
   input wire logic        rst,
   input wire logic        host_wr,
   input wire logic        host_rd,
   input wire logic [7:0]  host_addr,
   input wire logic        local_wr,
   input wire logic [7:0]  local_addr,
   input wire logic [31:0] local_wdata,
   input wire logic        data_parity_err,
   input wire logic [31:0] rdata,
   input wire logic        host_retry,
   input wire logic        local_irq
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic pm_wr;
   assign pm_wr = host_wr && host_addr[7:2] == 6'h17;
   // a retried write is already a seen request; its later acceptance
   // raises no new one, so it is left out of the request check
   logic pend;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pend <= 1'b0;
      end else if (host_retry) begin
         pend <= 1'b1;
      end else if ($past(pm_wr)) begin
         pend <= 1'b0;
      end
   end
   sequence parity_seen;
      data_parity_err ##[1:8]
      (host_rd && host_addr[7:2] == 6'h01 && !host_wr);
   endsequence
   irq_or_retry_a: assert property (
      pm_wr && !pend |=> local_irq || host_retry)
      else $error("pm write lost");
   retry_cause_a: assert property (
      host_retry |-> $past(pm_wr)) else $error("retry without pm write");
   cap_value_a: assert property (
      host_rd && host_addr[7:2] == 6'h16 |=>
      (rdata[31:16] & 16'hffdf) == 16'h0202) else $error("bad capability");
   pmcsr_zero_a: assert property (
      host_rd && host_addr[7:2] == 6'h17 |=> rdata[15:2] == 14'h0000)
      else $error("pmcsr constant bits");
   devsel_timing_a: assert property (
      host_rd && host_addr[7:2] == 6'h01 |=> rdata[26:25] == 2'h1)
      else $error("devsel timing field");
   bar_low_a: assert property (
      host_rd && (host_addr[7:2] == 6'h05 || host_addr[7:2] == 6'h06)
      |=> rdata[11:0] == 12'h008) else $error("base low bits");
   irq_clear_a: assert property (
      local_wr && local_addr[7:2] == 6'h19 && !local_wdata[3] && !host_wr
      |=> !local_irq) else $error("irq not cleared");
   parity_flag_a: assert property (
      parity_seen |=> rdata[31]) else $error("parity flag not set");
endmodule
bind pbpm_bank pbpm_bank_props u_props (.clk_sys(clk_sys), .rst(rst),
   .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr),
   .local_wr(local_wr), .local_addr(local_addr), .local_wdata(local_wdata),
   .data_parity_err(data_parity_err), .rdata(rdata),
   .host_retry(host_retry), .local_irq(local_irq));

// ==== verif/pbpm_bank_tb.sv ====
// self-checking bench of the bridge register bank
// host side through pbpm_host, local side and events driven here
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
   $display("mismatch %s exp %h got %h", n, e, g); end end
module pbpm_bank_tb;
   logic        clk_sys, rst, hw, hr, retry, irq, r, lw, lr;
   logic [7:0]  ha, la;
   logic [3:0]  hbe;
   logic [31:0] hd, ld, rdata, q;
   logic [9:0]  ev;
   int          num_errors = 0;
   int          checked = 0;
   pbpm_host h (.clk_sys(clk_sys), .rdata(rdata), .host_retry(retry),
      .host_wr(hw), .host_rd(hr), .host_addr(ha), .host_be(hbe),
      .host_wdata(hd));
   pbpm_bank DUT (.clk_sys(clk_sys), .rst(rst), .host_wr(hw), .host_rd(hr),
      .host_addr(ha), .host_be(hbe), .host_wdata(hd), .local_wr(lw),
      .local_rd(lr), .local_addr(la), .local_wdata(ld),
      .addr_parity_err(ev[0]), .data_parity_err(ev[1]),
      .system_error_pin(ev[2]), .master_abort_evt(ev[3]),
      .target_abort_evt(ev[4]), .signaled_abort_evt(ev[5]),
      .read_parity_err(ev[6]), .parity_error_pin(ev[7]),
      .master_write(ev[8]), .parity_response_enable(ev[9]),
      .rdata(rdata), .host_retry(retry), .local_irq(irq));
   task automatic conclude();
      $display("checked %0d num_errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic lx(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      #1;
      {lw, lr, la, ld} = {w, !w, a, d};
      @(posedge clk_sys);
      #1;
      {lw, lr} = 2'b00;
      q = rdata;
   endtask
   // pmcsr write, then read back the power state
   task automatic pm(input logic [3:0] be, input logic [1:0] s,
      input logic er, input logic [1:0] es);
      h.xfer(1'b1, 8'h5c, be, {30'h0, s}, q, r);
      `CHK("retry", er, r)
      h.xfer(1'b0, 8'h5c, 4'hf, 32'h0, q, r);
      `CHK("power state", es, q[1:0])
   endtask
   task automatic stat(input logic [9:0] e, input logic [15:0] exp);
      @(posedge clk_sys);
      #1;
      ev = e;
      repeat (4) @(posedge clk_sys);
      #1;
      ev = '0;
      repeat (3) @(posedge clk_sys);
      h.xfer(1'b0, 8'h04, 4'hf, 32'h0, q, r);
      `CHK("status", exp, q[31:16] & 16'hff00)
      h.xfer(1'b1, 8'h04, 4'hc, 32'hf900_0000, q, r);
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      #200000;
      num_errors++;
      conclude();
   end
   initial begin
      {rst, lw, lr, la, ld, ev} = {1'b1, 52'h0};
      repeat (5) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      h.xfer(1'b0, 8'h58, 4'hf, 32'h0, q, r);
      `CHK("capabilities", 16'h0202, q[31:16])
      h.xfer(1'b0, 8'h5c, 4'hf, 32'h0, q, r);
      `CHK("pmcsr", 16'h0000, q[15:0])
      lx(1'b0, 8'h64, 32'h0);
      `CHK("scrr", 8'h10, q[7:0])
      $display("reset values done");
      pm(4'h8, 2'h1, 1'b0, 2'h0);
      `CHK("irq", 1'b1, irq)
      lx(1'b1, 8'h64, 32'h10);
      pm(4'h1, 2'h1, 1'b0, 2'h1);
      lx(1'b1, 8'h64, 32'h16);
      lx(1'b0, 8'h64, 32'h0);
      `CHK("scrr", 8'h12, q[7:0])
      pm(4'h1, 2'h2, 1'b0, 2'h1);
      lx(1'b1, 8'h64, 32'h01);
      pm(4'h1, 2'h0, 1'b1, 2'h1);
      pm(4'h1, 2'h0, 1'b1, 2'h1);
      lx(1'b1, 8'h64, 32'h11);
      pm(4'h1, 2'h0, 1'b0, 2'h0);
      lx(1'b0, 8'h64, 32'h0);
      `CHK("scrr", 8'h01, q[7:0])
      lx(1'b1, 8'h64, 32'h11);
      pm(4'h1, 2'h3, 1'b0, 2'h3);
      pm(4'h1, 2'h0, 1'b0, 2'h0);
      $display("power handshake done");
      lx(1'b1, 8'h70, 32'hfff0_0000);
      lx(1'b1, 8'h74, 32'h8000_0000);
      for (int i = 0; i < 2; i++) begin
         h.xfer(1'b1, 8'h14 + 8'(4 * i), 4'hf, 32'hffff_ffff, q, r);
         h.xfer(1'b0, 8'h14 + 8'(4 * i), 4'hf, 32'h0, q, r);
         `CHK("base", i ? 32'h8000_0008 : 32'hfff0_0008, q)
      end
      $display("base registers done");
      stat(10'h3ff, 16'hfb00);
      stat(10'h000, 16'h0200);
      stat(10'h1c0, 16'h8200);
      $display("status flags done");
      conclude();
   end
endmodule

// ==== verif/pbpm_host.sv ====
// model of the host issuing configuration cycles
// assumes answers come one cycle after the strobe
`timescale 1ns/1ps
module pbpm_host (
   input  wire logic        clk_sys,
   input  wire logic [31:0] rdata,
   input  wire logic        host_retry,
   output logic             host_wr,
   output logic             host_rd,
   output logic [7:0]       host_addr,
   output logic [3:0]       host_be,
   output logic [31:0]      host_wdata
);
   initial begin
      {host_wr, host_rd, host_addr, host_be, host_wdata} = '0;
   end
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [3:0] be, input logic [31:0] d,
      output logic [31:0] q, output logic rty);
      @(posedge clk_sys);
      #1;
      {host_wr, host_rd, host_addr, host_be, host_wdata} = {w, !w, a, be, d};
      @(posedge clk_sys);
      #1;
      q = rdata;
      rty = host_retry;
      // released lines except the byte enables must not keep the last value
      {host_wr, host_rd, host_addr, host_wdata} = {2'b00, ~a, ~d};
   endtask
endmodule
